// ### verification/psc_host.sv
`timescale 1ns/1ns
module psc_host (
  output logic sclk,
  output logic sdata,
  output logic restart_n
);
  // lines always held at defined levels, never floating
  initial begin
    sclk = '0;
    sdata = '0;
    restart_n = 1'h1;
  end
  // one byte lsb first, 64 ns serial period
  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      sdata <= b[i];
      #32 sclk <= 1'h1;
      #32 sclk <= '0;
    end
  endtask
  // restart pin held low for t ns
  task automatic restart(input int t);
    restart_n <= '0;
    #t restart_n <= 1'h1;
  endtask
endmodule

// ### verification/psc_loader_tb_top.sv
`timescale 1ns/1ns
`include "psc_params.svh"
module psc_loader_tb_top;
  // ----------------------------
  // signals and instances
  // ----------------------------
  logic clk = '0;
  logic rst = 1'h1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic serial_load_clock, serial_data_in, restart_request_n, serial_data_out, serial_data_oe;
  logic load_error_status_n_out, load_error_status_n_oe, load_complete_out, load_complete_oe;
  logic init_done_out, init_done_oe, chain_enable_out_n, user_pullup_en, user_mode;
  logic chain_enable_in_n = '0, user_startup_clock = '0, uclk_run = '0;
  logic user_data_out = '0, user_data_oe = 1'h1;
  int n_errors = 0, cmp_count = 0;
  // wired-and lines with pull-ups
  wire load_error_status_n_in = load_error_status_n_oe ? load_error_status_n_out : 1'h1;
  wire load_complete_in = load_complete_oe ? load_complete_out : 1'h1;
  wire init_done_line = init_done_oe ? init_done_out : 1'h1;
  // system clock; user clock gated by uclk_run, stopped for a while during one start-up
  always #4 clk = ~clk;
  always #32 user_startup_clock = uclk_run & ~user_startup_clock;
  psc_loader #(.ERR_TIMEOUT_CYCLES(50), .INIT_OSC_TICKS(10), .USR_INIT_CYCLES(8)) dut (
    .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .serial_load_clock, .serial_data_in, .serial_data_out, .serial_data_oe, .restart_request_n,
    .load_error_status_n_in, .load_error_status_n_out, .load_error_status_n_oe,
    .load_complete_in, .load_complete_out, .load_complete_oe, .init_done_out, .init_done_oe,
    .chain_enable_in_n, .chain_enable_out_n, .user_startup_clock, .user_pullup_en,
    .user_mode, .user_data_out, .user_data_oe);
  psc_host host (.sclk(serial_load_clock), .sdata(serial_data_in), .restart_n(restart_request_n));
  // ----------------------------
  // tasks
  // ----------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] p;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(negedge clk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      p = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= '0;
      if (w) s_axi_wvalid <= '0;
    end while (b !== 1'h1);
    s_axi_bready <= '0;
    chk(p, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic t, r;
    logic [31:0] d;
    logic [1:0] p;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(negedge clk);
      t = s_axi_arready;
      r = s_axi_rvalid;
      d = s_axi_rdata;
      p = s_axi_rresp;
      @(posedge clk);
      if (t) s_axi_arvalid <= '0;
    end while (r !== 1'h1);
    s_axi_rready <= '0;
    chk(d, ed);
    chk(p, er);
  endtask
  // four byte stream with a long pause, checksum spoilt on request
  task automatic load(input logic [7:0] opt, input logic bad);
    // host waits for the status line released before sending
    while (load_error_status_n_in !== 1'h1) @(posedge clk);
    repeat (8) @(posedge clk);
    host.send_byte(`PSC_SYNC_BYTE);
    host.send_byte(opt);
    repeat (300) @(posedge clk);
    host.send_byte(8'h3c);
    host.send_byte(`PSC_SYNC_BYTE ^ opt ^ 8'h3c ^ {8{bad}});
    repeat (8) @(posedge clk);
  endtask
  task automatic wait_um();
    for (int i = 0; i < 400 && user_mode !== 1'h1; i++) @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ----------------------------
  // tests
  // ----------------------------
  initial begin
    #200000;
    n_errors++;
    wrap_up();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= '0;
    repeat (10) @(posedge clk);
    chk(init_done_oe, '0);
    chk(user_pullup_en, 1'h1);
    rd(`PSC_REG_LEN, `PSC_LEN_RESET, `PSC_RESP_OKAY);
    wr(`PSC_REG_LEN, 32'h4, `PSC_RESP_OKAY);
    wr(`PSC_REG_BYTES, 32'h4, `PSC_RESP_SLVERR);
    rd(8'h10, '0, `PSC_RESP_SLVERR);
    rd(`PSC_REG_LEN, 32'h4, `PSC_RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    wr(`PSC_REG_LEN, 32'h0000ff01, `PSC_RESP_OKAY);
    rd(`PSC_REG_LEN, 32'h3, `PSC_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    wr(`PSC_REG_LEN, 32'h4, `PSC_RESP_OKAY);
    $display("test registers done");
    load(8'h02, '0);
    chk(chain_enable_out_n, '0);
    chk(load_complete_oe, '0);
    chk(init_done_oe, 1'h1);
    repeat (100) @(posedge clk);
    chk(user_mode, '0);
    wait_um();
    chk(user_mode, 1'h1);
    chk(init_done_oe, '0);
    chk(init_done_line, 1'h1);
    chk(user_pullup_en, '0);
    chk(serial_data_oe, '0);
    rd(`PSC_REG_STATUS, 32'h727, `PSC_RESP_OKAY);
    host.send_byte(8'hff);
    chk(user_mode, 1'h1);
    rd(`PSC_REG_BYTES, 32'h4, `PSC_RESP_OKAY);
    host.restart(300);
    repeat (20) @(posedge clk);
    chk(user_mode, 1'h1);
    $display("test start-up done");
    fork
      host.restart(800);
      begin
        repeat (80) @(posedge clk);
        chk(load_error_status_n_oe, 1'h1);
        chk(load_complete_oe, 1'h1);
        chk(user_pullup_en, 1'h1);
      end
    join
    repeat (10) @(posedge clk);
    chk(load_error_status_n_oe, '0);
    $display("test restart done");
    load(8'h04, 1'h1);
    chk(load_error_status_n_oe, 1'h1);
    chk(load_complete_oe, 1'h1);
    repeat (60) @(posedge clk);
    chk(load_error_status_n_oe, '0);
    rd(`PSC_REG_ERRS, 32'h1, `PSC_RESP_OKAY);
    load(8'h00, 1'h1);
    repeat (100) @(posedge clk);
    chk(load_error_status_n_oe, 1'h1);
    host.restart(800);
    repeat (10) @(posedge clk);
    chk(load_error_status_n_oe, '0);
    $display("test errors done");
    chain_enable_in_n <= 1'h1;
    load(8'h02, '0);
    chk(load_complete_oe, 1'h1);
    chk(chain_enable_out_n, 1'h1);
    chain_enable_in_n <= '0;
    uclk_run <= 1'h1;
    load(8'h09, '0);
    chk(load_complete_oe, '0);
    uclk_run <= '0;
    repeat (50) @(posedge clk);
    chk(user_mode, '0);
    uclk_run <= 1'h1;
    wait_um();
    chk(user_mode, 1'h1);
    chk(serial_data_oe, 1'h1);
    user_data_out <= 1'h1;
    repeat (2) @(posedge clk);
    chk(serial_data_out, 1'h1);
    user_data_oe <= '0;
    @(posedge clk);
    chk(serial_data_oe, '0);
    $display("test chain and user clock done");
    wrap_up();
  end
endmodule

// ### verilog/psc_loader.sv
// Functional notes
// - start-up runs on internal 10 MHz tick unless user clock option set.
// - with oscillator, finish after full bitstream; later serial clocks ignored.
// - user clock ignored in load, enabled after delay, then 3187 cycles.
// - user clock edges never touch bitstream loading.
// - start-up-complete line released on entering user mode.
// - start-up-complete released in reset, driven low once its option loads.
// - user mode disables weak pull-ups and hands pins to the design.
// - serial data pin floats in user mode unless dual-purpose option.
// - serial clock may pause any length; no timeout on it.
// - on load error, drive status low and reset internally.
// - auto-restart releases status within 230 us; host may then reload.
// - restart low 500 ns pulls status and load-complete low, floats I/O.
// - selected device drives chain-enable out low once its load completes.
// - next chained device accepts data within one serial clock.
// - start-up waits for shared load-complete line to rise.
// - status low from any device halts loading for the chain.
// - grounded chain-enable inputs load the same bitstream in parallel.
// - data sampled on serial clock rise, bytes arrive LSB first.
// - load-complete released only after error-free load; start-up at its rise.
`timescale 1ns/1ns
`include "psc_params.svh"
module psc_loader #(
  parameter int AW = 8,
  parameter int unsigned ERR_TIMEOUT_CYCLES = `PSC_ERR_TIMEOUT_CYC,
  parameter int unsigned INIT_OSC_TICKS = `PSC_INIT_OSC_TICKS,
  parameter int unsigned USR_INIT_CYCLES = `PSC_USR_INIT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serial_load_clock,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  input wire logic restart_request_n,
  input wire logic load_error_status_n_in,
  output logic load_error_status_n_out,
  output logic load_error_status_n_oe,
  input wire logic load_complete_in,
  output logic load_complete_out,
  output logic load_complete_oe,
  output logic init_done_out,
  output logic init_done_oe,
  input wire logic chain_enable_in_n,
  output logic chain_enable_out_n,
  input wire logic user_startup_clock,
  output logic user_pullup_en,
  output logic user_mode,
  input wire logic user_data_out,
  input wire logic user_data_oe
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  psc_pkg::psc_pins_t pin_raw;
  psc_pkg::psc_pins_t pin;
  psc_pkg::psc_pins_t pin_rise;
  psc_pkg::psc_pins_t pin_fall;

  assign pin_raw = '{sclk: serial_load_clock, sdata: serial_data_in,
                     restart_n: restart_request_n, stat_n: load_error_status_n_in,
                     done: load_complete_in, ce_n: chain_enable_in_n,
                     uclk: user_startup_clock};

  // open-drain lines filtered like every pin
  psc_sync #(.W(7), .RST_VAL(`PSC_PIN_RESET)) u_sync (
    .clk(clk),
    .rst(rst),
    .d(pin_raw),
    .q(pin),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // ----------------------------------------
  // loader state
  // ----------------------------------------
  psc_pkg::psc_state_t state, next_state;
  psc_pkg::psc_opt_t opt, next_opt;
  logic opt_loaded, next_opt_loaded;
  logic [7:0] shreg, next_shreg;
  logic [2:0] bitcnt, next_bitcnt;
  logic [15:0] bytecnt, next_bytecnt;
  logic [7:0] csum, next_csum;
  logic [15:0] timer, next_timer;
  logic [15:0] rlow, next_rlow;
  logic [3:0] osc, next_osc;
  logic [7:0] errs, next_errs;
  logic sdo, next_sdo;
  logic [15:0] len;
  logic osc_tick;
  logic restart_long;
  logic [7:0] byte_in;
  logic byte_done;
  logic byte_bad;
  logic init_tick;
  logic [15:0] init_end;

  assign osc_tick = (osc == 4'(`PSC_OSC_DIV - 1));
  assign restart_long = (rlow == 16'(`PSC_RESTART_MIN_CYC));
  assign byte_in = {pin.sdata, shreg[7:1]};
  // a byte completes on the eighth rising serial clock while selected
  assign byte_done = (state == psc_pkg::S_LOAD) && pin_rise.sclk
                     && !pin.ce_n && (bitcnt == 3'h7);
  assign byte_bad = ((bytecnt == 16'h0000) && (byte_in != `PSC_SYNC_BYTE))
                    || ((bytecnt == len - 16'h0001) && (byte_in != csum));
  // start-up clock source choice
  assign init_tick = opt.usr_clk ? pin_rise.uclk : osc_tick;
  assign init_end = opt.usr_clk ? 16'(USR_INIT_CYCLES - 1)
                                : 16'(INIT_OSC_TICKS - 1);

  // next-state logic for loader and start-up
  always_comb begin
    next_state = state;
    next_opt = opt;
    next_opt_loaded = opt_loaded;
    next_shreg = shreg;
    next_bitcnt = bitcnt;
    next_bytecnt = bytecnt;
    next_csum = csum;
    next_timer = timer;
    next_errs = errs;
    next_osc = osc_tick ? 4'h0 : osc + 4'h1;
    next_sdo = user_data_out;
    // restart low width, saturating
    if (pin.restart_n) begin
      next_rlow = 16'h0000;
    end else if (!restart_long) begin
      next_rlow = rlow + 16'h0001;
    end else begin
      next_rlow = rlow;
    end
    case (state)
      psc_pkg::S_RST: begin
        if (pin.restart_n) begin
          next_state = psc_pkg::S_LOAD;
        end
      end
      psc_pkg::S_LOAD: begin
        // only serial clock edges load bits, user clock never
        if (pin_rise.sclk && !pin.ce_n) begin
          next_shreg = byte_in;
          next_bitcnt = bitcnt + 3'h1;
        end
        if (byte_done) begin
          next_bytecnt = bytecnt + 16'h0001;
          next_csum = csum ^ byte_in;
          if (bytecnt == `PSC_OPT_BYTE_IDX) begin
            next_opt = psc_pkg::psc_opt_t'(byte_in[3:0]);
            next_opt_loaded = 1'b1;
          end
          if (byte_bad) begin
            next_state = psc_pkg::S_ERR;
            next_timer = 16'h0000;
            next_errs = errs + 8'h01;
          end else if (bytecnt == len - 16'h0001) begin
            next_state = psc_pkg::S_DONE;
          end
        end
      end
      psc_pkg::S_DONE: begin
        // serial clock no longer looked at here
        next_timer = 16'h0000;
        if (pin.done) begin
          next_state = opt.usr_clk ? psc_pkg::S_CUDLY : psc_pkg::S_INIT;
        end
      end
      psc_pkg::S_CUDLY: begin
        // user clock held off for the enable delay
        if (timer == 16'(`PSC_CU_DELAY_CYC - 1)) begin
          next_state = psc_pkg::S_INIT;
          next_timer = 16'h0000;
        end else begin
          next_timer = timer + 16'h0001;
        end
      end
      psc_pkg::S_INIT: begin
        if (init_tick) begin
          if (timer == init_end) begin
            next_state = psc_pkg::S_USER;
          end else begin
            next_timer = timer + 16'h0001;
          end
        end
      end
      psc_pkg::S_ERR: begin
        // internal reset, release after timeout if enabled
        next_bitcnt = 3'h0;
        next_bytecnt = 16'h0000;
        next_timer = timer + 16'h0001;
        if (opt.auto_rst && (timer == 16'(ERR_TIMEOUT_CYCLES - 1))) begin
          next_state = psc_pkg::S_LOAD;
        end
      end
      psc_pkg::S_HOLD: begin
        if (pin.stat_n) begin
          next_state = psc_pkg::S_LOAD;
        end
      end
      default: begin
        next_state = state;
      end
    endcase
    // another device pulled status low: stop with the chain
    if ((state == psc_pkg::S_LOAD || state == psc_pkg::S_DONE
         || state == psc_pkg::S_CUDLY || state == psc_pkg::S_INIT)
        && !pin.stat_n && next_state != psc_pkg::S_ERR) begin
      next_state = psc_pkg::S_HOLD;
    end
    // long restart pulse wins from any state
    if (restart_long) begin
      next_state = psc_pkg::S_RST;
    end
    // fresh load: clear everything the bitstream fills
    if (next_state == psc_pkg::S_LOAD && state != psc_pkg::S_LOAD) begin
      next_opt = '0;
      next_opt_loaded = 1'b0;
      next_bitcnt = 3'h0;
      next_bytecnt = 16'h0000;
      next_csum = 8'h00;
      next_shreg = 8'h00;
    end
  end

  // loader registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= psc_pkg::S_RST;
      opt <= '0;
      opt_loaded <= 1'b0;
      shreg <= 8'h00;
      bitcnt <= 3'h0;
      bytecnt <= 16'h0000;
      csum <= 8'h00;
      timer <= 16'h0000;
      rlow <= 16'h0000;
      osc <= 4'h0;
      errs <= 8'h00;
      sdo <= 1'b0;
    end else begin
      state <= next_state;
      opt <= next_opt;
      opt_loaded <= next_opt_loaded;
      shreg <= next_shreg;
      bitcnt <= next_bitcnt;
      bytecnt <= next_bytecnt;
      csum <= next_csum;
      timer <= next_timer;
      rlow <= next_rlow;
      osc <= next_osc;
      errs <= next_errs;
      sdo <= next_sdo;
    end
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  assign load_error_status_n_out = 1'b0;
  assign load_error_status_n_oe = (state == psc_pkg::S_RST)
                                  || (state == psc_pkg::S_ERR);
  assign load_complete_out = 1'b0;
  assign load_complete_oe = (state == psc_pkg::S_RST) || (state == psc_pkg::S_LOAD)
                            || (state == psc_pkg::S_ERR)
                            || (state == psc_pkg::S_HOLD);
  assign init_done_out = 1'b0;
  assign init_done_oe = opt_loaded && opt.init_en
                        && (state == psc_pkg::S_LOAD || state == psc_pkg::S_DONE
                            || state == psc_pkg::S_CUDLY
                            || state == psc_pkg::S_INIT);
  assign chain_enable_out_n = !(state == psc_pkg::S_DONE || state == psc_pkg::S_CUDLY
                                || state == psc_pkg::S_INIT
                                || state == psc_pkg::S_USER);
  assign user_mode = (state == psc_pkg::S_USER);
  assign user_pullup_en = !user_mode;
  assign serial_data_out = sdo;
  assign serial_data_oe = user_mode && opt.dual && user_data_oe;

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic aw_got, next_aw_got;
  logic w_got, next_w_got;
  logic [AW-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;
  logic [15:0] next_len;
  logic [15:0] wlen;

  assign s_axi_awready = !aw_got && !bvalid;
  assign s_axi_wready = !w_got && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // bus next values: capture, write, read mux
  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_len = len;
    wlen = len;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // both halves held: perform the write
    if (aw_got && w_got && !bvalid) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `PSC_RESP_SLVERR;
      if (aw_addr == `PSC_REG_LEN) begin
        if (w_strb[0]) wlen[7:0] = w_data[7:0];
        if (w_strb[1]) wlen[15:8] = w_data[15:8];
        next_len = (wlen < `PSC_LEN_MIN) ? `PSC_LEN_MIN : wlen;
        next_bresp = `PSC_RESP_OKAY;
      end
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = `PSC_RESP_OKAY;
      if (s_axi_araddr == `PSC_REG_STATUS) begin
        next_rdata = {21'h0, pin.done, pin.stat_n, opt_loaded, opt, 1'b0, state};
      end else if (s_axi_araddr == `PSC_REG_LEN) begin
        next_rdata = {16'h0, len};
      end else if (s_axi_araddr == `PSC_REG_BYTES) begin
        next_rdata = {16'h0, bytecnt};
      end else if (s_axi_araddr == `PSC_REG_ERRS) begin
        next_rdata = {24'h0, errs};
      end else begin
        next_rdata = 32'h0;
        next_rresp = `PSC_RESP_SLVERR;
      end
    end
  end

  // bus registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= 2'h0;
      len <= `PSC_LEN_RESET;
    end else begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      len <= next_len;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_err_drive;
    @(posedge clk) disable iff (rst)
    byte_done && byte_bad && !restart_long |=> state == psc_pkg::S_ERR
      && load_error_status_n_oe && load_complete_oe;
  endproperty
  a_err_drive: assert property (p_err_drive) else $error("error not flagged");

  property p_err_bound;
    @(posedge clk) disable iff (rst)
    state == psc_pkg::S_ERR |-> timer < 16'(ERR_TIMEOUT_CYCLES) || !opt.auto_rst;
  endproperty
  a_err_bound: assert property (p_err_bound) else $error("status held too long");

  property p_done_release;
    @(posedge clk) disable iff (rst)
    state == psc_pkg::S_DONE |-> !load_complete_oe && !chain_enable_out_n;
  endproperty
  a_done_release: assert property (p_done_release) else $error("done lines wrong");

  property p_wait_shared;
    @(posedge clk) disable iff (rst)
    state == psc_pkg::S_DONE ##1 (state == psc_pkg::S_CUDLY
      || state == psc_pkg::S_INIT) |-> $past(pin.done);
  endproperty
  a_wait_shared: assert property (p_wait_shared) else $error("early start-up");

  property p_cu_delay;
    @(posedge clk) disable iff (rst)
    $past(state) == psc_pkg::S_CUDLY && state == psc_pkg::S_INIT
      |-> $past(timer) == 16'(`PSC_CU_DELAY_CYC - 1);
  endproperty
  a_cu_delay: assert property (p_cu_delay) else $error("enable delay wrong");

  property p_user_release;
    @(posedge clk) disable iff (rst)
    $rose(user_mode) |-> !init_done_oe && !user_pullup_en;
  endproperty
  a_user_release: assert property (p_user_release) else $error("user entry wrong");

  property p_init_done_reset;
    @(posedge clk) disable iff (rst)
    state == psc_pkg::S_RST |=> !init_done_oe;
  endproperty
  a_init_done_reset: assert property (p_init_done_reset) else $error("start line low");

  property p_restart;
    @(posedge clk) disable iff (rst)
    restart_long |=> state == psc_pkg::S_RST && load_error_status_n_oe
      && load_complete_oe && !serial_data_oe;
  endproperty
  a_restart: assert property (p_restart) else $error("restart not taken");

  property p_ignore_sclk;
    @(posedge clk) disable iff (rst)
    (state == psc_pkg::S_DONE || state == psc_pkg::S_CUDLY || state == psc_pkg::S_INIT
      || state == psc_pkg::S_USER) && pin_rise.sclk && !restart_long |=> $stable(bytecnt);
  endproperty
  a_ignore_sclk: assert property (p_ignore_sclk) else $error("bits after load");

  property p_data_float;
    @(posedge clk) disable iff (rst)
    !opt.dual || !user_mode |-> !serial_data_oe;
  endproperty
  a_data_float: assert property (p_data_float) else $error("data pin driven");

endmodule

// ### verilog/psc_params.svh
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define PSC_CLK_MHZ 125
`define PSC_OSC_MHZ 10
// oscillator tick divider, rounded down
`define PSC_OSC_DIV (`PSC_CLK_MHZ / `PSC_OSC_MHZ)
// start-up length on the oscillator, in microseconds
`define PSC_INIT_US 300
`define PSC_INIT_OSC_TICKS (`PSC_INIT_US * `PSC_OSC_MHZ)
// start-up length on the user clock, in its cycles
`define PSC_USR_INIT_CYCLES 3187
// user clock enable delay after load complete, least time
`define PSC_CU_DELAY_NS 30
`define PSC_CU_DELAY_CYC ((`PSC_CU_DELAY_NS * `PSC_CLK_MHZ + 999) / 1000)
// error status release, longest time
`define PSC_ERR_TIMEOUT_US 230
`define PSC_ERR_TIMEOUT_CYC (`PSC_ERR_TIMEOUT_US * `PSC_CLK_MHZ)
// least restart low pulse
`define PSC_RESTART_MIN_NS 500
`define PSC_RESTART_MIN_CYC ((`PSC_RESTART_MIN_NS * `PSC_CLK_MHZ + 999) / 1000)

// ----------------------------------------
// bitstream framing
// ----------------------------------------
`define PSC_SYNC_BYTE 8'ha5
`define PSC_OPT_BYTE_IDX 16'h0001

// ----------------------------------------
// register map
// ----------------------------------------
`define PSC_REG_STATUS 8'h00
`define PSC_REG_LEN 8'h04
`define PSC_REG_BYTES 8'h08
`define PSC_REG_ERRS 8'h0c
`define PSC_LEN_RESET 16'h0010
`define PSC_LEN_MIN 16'h0003
`define PSC_RESP_OKAY 2'h0
`define PSC_RESP_SLVERR 2'h2
// input pin reset levels, see psc_pins_t order
`define PSC_PIN_RESET 7'h1e

`endif

// ### verilog/psc_pkg.sv
package psc_pkg;

  // ----------------------------------------
  // loader states, gray along the load path through S_CUDLY; S_DONE to S_INIT flips two bits
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_RST = 3'h0,
    S_LOAD = 3'h1,
    S_DONE = 3'h3,
    S_CUDLY = 3'h2,
    S_INIT = 3'h6,
    S_USER = 3'h7,
    S_ERR = 3'h5,
    S_HOLD = 3'h4
  } psc_state_t;

  // option bits carried in the bitstream
  typedef struct packed {
    logic dual;
    logic auto_rst;
    logic init_en;
    logic usr_clk;
  } psc_opt_t;

  // synchronised pin inputs
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic restart_n;
    logic stat_n;
    logic done;
    logic ce_n;
    logic uclk;
  } psc_pins_t;

endpackage

// ### verilog/psc_sync.sv
`timescale 1ns/1ns
module psc_sync #(
  parameter int W = 7,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  // ----------------------------------------
  // five flops per bit, level taken when 2 and 3 agree
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic prev;
      logic next_lvl;
      // filter: only stage 2 and 3 are compared
      always_comb begin
        next_lvl = (s2 == s3) ? s3 : lvl;
      end
      // registers, stage 1 read by stage 2 only
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1 <= RST_VAL[i];
          s2 <= RST_VAL[i];
          s3 <= RST_VAL[i];
          lvl <= RST_VAL[i];
          prev <= RST_VAL[i];
        end else begin
          s1 <= d[i];
          s2 <= s1;
          s3 <= s2;
          lvl <= next_lvl;
          prev <= lvl;
        end
      end
      assign q[i] = lvl;
      assign rise[i] = lvl & ~prev;
      assign fall[i] = ~lvl & prev;
    end
  endgenerate

endmodule
